// >>> bench/psb_gate_drv_model.sv
`timescale 1ns/1ps
// *****************************************
// gate driver and bridge leg model
// *****************************************
module psb_gate_drv_model (
  input wire logic clk,
  input wire logic [3:0] drv,
  output logic [1:0] node,
  output int shoot_cnt
);
  // a leg with both switches off floats, so its node rings rather than holding
  initial begin
    node = 2'h0;
    shoot_cnt = 0;
    forever begin
      @(posedge clk);
      for (int k = 0; k < 2; k++) begin
        if (drv[3-2*k] && drv[2-2*k]) shoot_cnt = shoot_cnt + 1;
        node[k] <= drv[3-2*k] ? 1'b1 : (drv[2-2*k] ? 1'b0 : ~node[k]);
      end
    end
  end
endmodule

// >>> bench/psb_pwm_ctrl_tb.sv
`timescale 1ns/1ps
module psb_pwm_ctrl_tb
  import psb_pkg::*;
;
  // *****************************************
  // stimulus and observed signals
  // *****************************************
  logic clk_sys, sys_rst, clk_en, peak_mode, l1h, l1l, l2h, l2l;
  logic ss_charge, ss_sink, ss_disch, low_iq, ref_en, s;
  psb_cmp_t cmp_in;
  logic [7:0] ea_code, ss_code, cs_code, ads_code, ea_limit, del_level;
  logic [15:0] osc_period, phase_shift;
  psb_leg_cfg_t leg1_cfg, leg2_cfg;
  logic [3:0] drv;
  logic [1:0] node;
  int shoot_cnt;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  assign drv = {l1h, l1l, l2h, l2l};

  // clock, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  psb_pwm_ctrl i_psb_pwm_ctrl (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CLK_EN(clk_en),
    .CMP_IN(cmp_in), .EA_CODE(ea_code), .SS_CODE(ss_code), .CS_CODE(cs_code),
    .ADS_CODE(ads_code), .OSC_PERIOD(osc_period), .PHASE_SHIFT(phase_shift),
    .PEAK_MODE(peak_mode), .LEG1_CFG(leg1_cfg), .LEG2_CFG(leg2_cfg),
    .LEG1_HIGH_DRIVE(l1h), .LEG1_LOW_DRIVE(l1l), .LEG2_HIGH_DRIVE(l2h),
    .LEG2_LOW_DRIVE(l2l), .SS_CHARGE(ss_charge), .SS_SINK(ss_sink),
    .SS_DISCHARGE(ss_disch), .LOW_IQ(low_iq), .REF_ENABLE(ref_en),
    .EA_LIMIT(ea_limit), .DEL_LEVEL(del_level));

  psb_gate_drv_model i_psb_gate_drv_model (.clk(clk_sys), .drv(drv), .node(node),
    .shoot_cnt(shoot_cnt));

  // *****************************************
  // helpers
  // *****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // high time, dead gap and low time of leg k, bounded so a stuck leg cannot hang
  task automatic meas(input int k, output int hi, output int gap, output int lo);
    int n;
    n = 0; hi = 0; gap = 0; lo = 0;
    while (drv[3-2*k] !== 1'b0 && n < 300) begin cyc(1); n++; end
    while (drv[3-2*k] !== 1'b1 && n < 300) begin cyc(1); n++; end
    while (drv[3-2*k] === 1'b1 && n < 300) begin cyc(1); n++; hi++; end
    while (drv[2-2*k] !== 1'b1 && n < 300) begin cyc(1); n++; gap++; end
    while (drv[2-2*k] === 1'b1 && n < 300) begin cyc(1); n++; lo++; end
  endtask

  // cycles from a rise of drive a to the next rise of drive b
  task automatic lag(input int a, input int b, output int d);
    int n;
    n = 0; d = 0;
    while (drv[a] !== 1'b0 && n < 300) begin cyc(1); n++; end
    while (drv[a] !== 1'b1 && n < 300) begin cyc(1); n++; end
    while (drv[b] !== 1'b1 && d < 60) begin cyc(1); d++; end
  endtask

  task automatic act(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      cyc(1);
      if (drv !== 4'h0) seen = 1'b1;
    end
  endtask

  // *****************************************
  // scenarios
  // *****************************************
  task automatic t_start;
    logic [3:0] d0;
    cyc(10);
    chk_bit(ss_charge, 1'b1);
    chk_bit(ss_disch, 1'b0);
    chk_bit(ref_en, 1'b1);
    chk_bit(low_iq, 1'b0);
    chk_val(16'(ea_limit), 16'h00FF);
    act(60, s);
    chk_bit(s, 1'b1);
    // a low enable must freeze the drives where they stand
    @(negedge clk_sys) clk_en = 1'b0;
    cyc(1);
    d0 = drv;
    cyc(30);
    chk_val(16'(drv), 16'(d0));
    @(negedge clk_sys) clk_en = 1'b1;
  endtask

  task automatic t_dead;
    int hi, gap, lo;
    logic [7:0] cs [2] = '{8'h00, 8'hC8};
    int dt [2] = '{10, 4};
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_sys) cs_code = cs[i];
      cyc(60);
      meas(0, hi, gap, lo);
      chk_val(16'(gap), 16'(dt[i]));
      chk_val(16'(hi), 16'(20 - dt[i]));
      chk_val(16'(lo), 16'(hi));
      meas(1, hi, gap, lo);
      chk_val(16'(gap), 16'h0000);
      chk_val(16'(hi), 16'(20));
      chk_val(16'(lo), 16'(20));
    end
    @(negedge clk_sys) cs_code = 8'h00;
  endtask

  task automatic t_del;
    logic [7:0] tc [5] = '{8'h00, 8'hC8, 8'h64, 8'h10, 8'h80};
    logic [7:0] ta [5] = '{8'h00, 8'h00, 8'h32, 8'h40, 8'h80};
    logic [7:0] te [5] = '{8'h32, 8'hC8, 8'h57, 8'h32, 8'h32};
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys);
      cs_code = tc[i];
      ads_code = ta[i];
      cyc(4);
      chk_val(16'(del_level), 16'(te[i]));
    end
    @(negedge clk_sys);
    cs_code = 8'h00;
    ads_code = 8'h00;
  endtask

  task automatic t_phase;
    int d;
    int ps [2] = '{5, 30};
    int ex [2] = '{5, 19};
    @(negedge clk_sys) leg1_cfg.tied_ref = 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_sys) phase_shift = 16'(ps[i]);
      // the transient after a shift change may bend leg two duty, so let it settle
      cyc(80);
      lag(3, 1, d);
      chk_val(16'(d), 16'(ex[i]));
      chk_bit(node[0], 1'b1);
      lag(2, 0, d);
      chk_val(16'(d), 16'(ex[i]));
    end
    @(negedge clk_sys);
    peak_mode = 1'b1;
    cmp_in.peak_cur = 1'b1;
    phase_shift = 16'h000A;
    cyc(80);
    lag(3, 1, d);
    chk_val(16'(d), 16'h0001);
    @(negedge clk_sys);
    peak_mode = 1'b0;
    cmp_in.peak_cur = 1'b0;
    phase_shift = 16'h0000;
    leg1_cfg.tied_ref = 1'b0;
  endtask

  task automatic t_noload;
    logic [7:0] ea [4] = '{8'h20, 8'h3C, 8'h3D, 8'h37};
    logic on [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    @(negedge clk_sys) ss_code = 8'h40;
    cyc(4);
    chk_val(16'(ea_limit), 16'h0040);
    @(negedge clk_sys) ss_code = 8'hFF;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys) ea_code = ea[i];
      cyc(8);
      chk_val(16'(ea_limit), 16'(ea[i]));
      act(60, s);
      chk_bit(s, on[i]);
    end
    @(negedge clk_sys) ea_code = 8'hFF;
  endtask

  task automatic t_ocp;
    @(negedge clk_sys) cmp_in.over_cur = 1'b1;
    cyc(3);
    chk_val(16'(drv), 16'h0000);
    chk_bit(ss_sink, 1'b1);
    chk_bit(ss_charge, 1'b0);
    @(negedge clk_sys) cmp_in.over_cur = 1'b0;
    act(40, s);
    chk_bit(s, 1'b0);
    chk_bit(ss_sink, 1'b1);
    @(negedge clk_sys) cmp_in.ss_low = 1'b1;
    cyc(3);
    chk_bit(ss_charge, 1'b1);
    chk_bit(ss_sink, 1'b0);
    @(negedge clk_sys) cmp_in.ss_low = 1'b0;
    act(80, s);
    chk_bit(s, 1'b1);
  endtask

  task automatic t_hard;
    // uvlo, reference low, node held low: {discharge, ref on, low iq}
    psb_cmp_t cv [3] = '{5'h10, 5'h08, 5'h04};
    logic [2:0] ex [3] = '{3'b101, 3'b110, 3'b010};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys) cmp_in = cv[i];
      cyc(3);
      chk_val(16'(drv), 16'h0000);
      chk_bit(ss_disch, ex[i][2]);
      chk_bit(ref_en, ex[i][1]);
      chk_bit(low_iq, ex[i][0]);
      @(negedge clk_sys) cmp_in = 5'h00;
      act(100, s);
      chk_bit(s, 1'b1);
    end
  endtask

  // *****************************************
  // main sequence and hang guard
  // *****************************************
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    cmp_in = 5'h00;
    ea_code = 8'hFF;
    ss_code = 8'hFF;
    cs_code = 8'h00;
    ads_code = 8'h00;
    osc_period = 16'h0014;
    phase_shift = 16'h0000;
    peak_mode = 1'b0;
    leg1_cfg = '{res_ohm: 16'h0C80, tied_ref: 1'b0};
    leg2_cfg = '{res_ohm: 16'h0C80, tied_ref: 1'b1};
    cyc(5);
    chk_val(16'(drv), 16'h0000);
    chk_bit(ss_disch, 1'b1);
    chk_bit(low_iq, 1'b1);
    chk_bit(ref_en, 1'b0);
    chk_val(16'(del_level), 16'h0032);
    @(negedge clk_sys) sys_rst = 1'b0;
    t_start();
    t_dead();
    t_del();
    t_phase();
    t_noload();
    t_ocp();
    t_hard();
    chk_val(16'(shoot_cnt), 16'h0000);
    close_out();
  end
endmodule

// >>> core/psb_leg.sv
`timescale 1ns/1ps
module psb_leg
  import psb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic phase_in,
  input wire logic [7:0] dt_in,
  input wire logic kill,
  output logic hi_drive,
  output logic lo_drive
);

  logic ph_reg;
  logic [7:0] gap_reg;

  // ***************************************************
  // dead-time insertion for one half-bridge
  // ***************************************************
  // the gap count is captured at the phase change and then counts down to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_reg <= 1'b0;
      gap_reg <= DT_RESET;
      hi_drive <= 1'b0;
      lo_drive <= 1'b0;
    end else if (ce) begin
      if (kill) begin
        ph_reg <= phase_in;
        gap_reg <= DT_RESET;
        hi_drive <= 1'b0;
        lo_drive <= 1'b0;
      end else if (phase_in != ph_reg) begin
        ph_reg <= phase_in;
        if (dt_in == DT_RESET) begin
          hi_drive <= phase_in;
          lo_drive <= ~phase_in;
          gap_reg <= DT_RESET;
        end else begin
          hi_drive <= 1'b0;
          lo_drive <= 1'b0;
          gap_reg <= dt_in - 8'h01;
        end
      end else if (gap_reg != DT_RESET) begin
        gap_reg <= gap_reg - 8'h01;
      end else begin
        hi_drive <= ph_reg; // complementary pair
        lo_drive <= ~ph_reg;
      end
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  no_overlap_a : assert property (
    !(hi_drive && lo_drive)) else $error("both drives of a leg high");

  dead_gap_a : assert property (
    ce && !kill && phase_in != ph_reg && dt_in > 8'h01
    |=> !hi_drive && !lo_drive && gap_reg == $past(dt_in) - 8'h01)
    else $error("dead time not inserted");

  bypass_a : assert property (
    ce && !kill && phase_in != ph_reg && dt_in == 8'h00
    |=> hi_drive == $past(phase_in) && lo_drive != $past(phase_in))
    else $error("bypassed leg did not switch at once");

endmodule

// >>> core/psb_pkg.sv
package psb_pkg;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_PS = 20000; // 50 MHz system clock
  localparam int DT_OFFSET_NS = 25; // fixed part of each dead time
  // least time, so round up to whole cycles
  localparam int DT_OFFSET_CYC = (DT_OFFSET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DEL_K_PS = 25; // picoseconds per ohm per volt
  localparam int CODE_PER_V = 100; // level codes are 10 mV steps
  // divisor turning ohms / level code into clock cycles
  localparam int DT_DIV = CLK_PERIOD_PS / (DEL_K_PS * CODE_PER_V);

  // ***************************************************
  // analog levels as 10 mV codes
  // ***************************************************
  localparam logic [7:0] VDEL_MIN = 8'h32; // 0.5 V floor of the delay level
  localparam logic [9:0] VDEL_GAIN_NUM = 10'h003; // gain 3/4, numerator
  localparam int VDEL_GAIN_SHIFT = 2; // gain 3/4, denominator as a shift
  localparam logic [7:0] NOLOAD_OFF = 8'h32; // 500 mV
  localparam logic [7:0] NOLOAD_ON = 8'h3C; // 600 mV

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // synchroniser contents after reset read as lockout with all codes zero,
  // so nothing starts on stale reset values before real samples arrive
  localparam logic [36:0] SYNC_RESET = 37'h1000000000;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [7:0] DT_RESET = 8'h00;

  // ***************************************************
  // types
  // ***************************************************
  typedef struct packed {
    logic uvlo; // supply below lockout threshold
    logic ref_low; // reference below 4 V
    logic ss_low; // soft-start node below 0.5 V
    logic over_cur; // sensed current at 2.5 V
    logic peak_cur; // sensed current at peak threshold
  } psb_cmp_t;

  typedef struct packed {
    logic [15:0] res_ohm; // programming resistance in ohms
    logic tied_ref; // delay input tied to the reference
  } psb_leg_cfg_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_START = 3'b010,
    ST_STOP = 3'b100
  } psb_state_t;

endpackage

// >>> core/psb_pwm_ctrl.sv
`timescale 1ns/1ps
// Operation
// - leg one pair toggles complementary, near 50% duty, half oscillator rate
// - leg two pair behaves like leg one, driving the other half-bridge
// - leg two outputs are phase shifted against the matching leg one outputs
// - leg two duty may leave 50% while the phase offset changes
// - each leg inserts dead time from its own independent setting
// - dead time is 25 ns plus resistance over delay level
// - a delay input tied to reference disables that leg's dead time
// - delay level is 0.75 times sense minus adaptive, plus 0.5 V, floored
// - adaptive grounded gives 4:1 dead time range; tied to sense, none
// - no-load stops outputs below 500 mV, resumes above 600 mV
// - error amplifier output is limited to the soft-start level
// - fast shutdown on node below 0.5 V, reference below 4 V, or lockout
// - reference fault or lockout discharges the soft-start node to ground
// - overcurrent starts soft stop, sinking ten times until node below 0.5 V
// - any fault or no-load stop drives all four outputs low at once; a low enable freezes them
// - an overcurrent shutdown restarts through a complete soft start
// - soft start charges the node once faults clear or soft stop ends
// - low supply-current state only during undervoltage lockout
// - peak current ends each active phase; overcurrent acts in every mode
// - reference stays on except during undervoltage lockout
module psb_pwm_ctrl
  import psb_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire psb_cmp_t CMP_IN,
  input wire logic [7:0] EA_CODE,
  input wire logic [7:0] SS_CODE,
  input wire logic [7:0] CS_CODE,
  input wire logic [7:0] ADS_CODE,
  input wire logic [15:0] OSC_PERIOD,
  input wire logic [15:0] PHASE_SHIFT,
  input wire logic PEAK_MODE,
  input wire psb_leg_cfg_t LEG1_CFG,
  input wire psb_leg_cfg_t LEG2_CFG,
  output logic LEG1_HIGH_DRIVE,
  output logic LEG1_LOW_DRIVE,
  output logic LEG2_HIGH_DRIVE,
  output logic LEG2_LOW_DRIVE,
  output logic SS_CHARGE,
  output logic SS_SINK,
  output logic SS_DISCHARGE,
  output logic LOW_IQ,
  output logic REF_ENABLE,
  output logic [7:0] EA_LIMIT,
  output logic [7:0] DEL_LEVEL
);

  // ***************************************************
  // input synchronisers
  // ***************************************************
  logic [36:0] meta_reg;
  logic [36:0] sync_reg;
  psb_cmp_t cmp_s;
  logic [7:0] ea_s;
  logic [7:0] ss_s;
  logic [7:0] cs_s;
  logic [7:0] ads_s;

  // level codes come from converters that update slowly, so a code
  // that lands mid-change is off by one sample at most
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
    end else if (CLK_EN) begin
      meta_reg <= {CMP_IN, EA_CODE, SS_CODE, CS_CODE, ADS_CODE};
      sync_reg <= meta_reg;
    end
  end

  assign {cmp_s, ea_s, ss_s, cs_s, ads_s} = sync_reg;

  // ***************************************************
  // oscillator and phase timing
  // ***************************************************
  logic [15:0] osc_cnt_reg;
  logic [15:0] phase_lat_reg;
  logic [15:0] lag_cnt_reg;
  logic [15:0] ph_clamp;
  logic tick;
  logic trip;
  logic lag_pend_reg;
  logic leg1_ph_reg;
  logic leg2_ph_reg;

  assign tick = ({1'b0, osc_cnt_reg} + 17'h00001) >= {1'b0, OSC_PERIOD};
  // an offset of a whole period or more would never fire
  assign ph_clamp = (PHASE_SHIFT >= OSC_PERIOD) ? OSC_PERIOD - 16'h0001 : PHASE_SHIFT;
  // current trip only shapes the pulse in peak current mode
  assign trip = PEAK_MODE && cmp_s.peak_cur;

  // free-running oscillator count
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      osc_cnt_reg <= CNT_RESET;
    end else if (CLK_EN) begin
      osc_cnt_reg <= tick ? CNT_RESET : osc_cnt_reg + 16'h0001;
    end
  end

  // leg one flips every oscillator period, so it runs at half the rate
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      leg1_ph_reg <= 1'b0;
    end else if (CLK_EN && tick) begin
      leg1_ph_reg <= ~leg1_ph_reg;
    end
  end

  // leg two follows leg one after the latched offset; a new offset takes
  // effect at the next flip, so one leg two half period stretches or shrinks
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      leg2_ph_reg <= 1'b0;
      lag_pend_reg <= 1'b0;
      lag_cnt_reg <= CNT_RESET;
      phase_lat_reg <= CNT_RESET;
    end else if (CLK_EN) begin
      if (tick) begin
        phase_lat_reg <= ph_clamp;
        if (ph_clamp == CNT_RESET) begin
          leg2_ph_reg <= ~leg1_ph_reg;
          lag_pend_reg <= 1'b0;
        end else begin
          lag_pend_reg <= 1'b1;
          lag_cnt_reg <= 16'h0001;
        end
      end else if (lag_pend_reg && (lag_cnt_reg == phase_lat_reg || trip)) begin
        leg2_ph_reg <= leg1_ph_reg;
        lag_pend_reg <= 1'b0;
      end else if (lag_pend_reg) begin
        lag_cnt_reg <= lag_cnt_reg + 16'h0001;
      end
    end
  end

  // ***************************************************
  // delay level and dead times
  // ***************************************************
  logic [7:0] vdel_diff;
  logic [9:0] vdel_prod;
  logic [7:0] vdel_next;
  logic [7:0] dt1;
  logic [7:0] dt2;

  function automatic logic [7:0] dt_cycles(input psb_leg_cfg_t cfg, input logic [7:0] vdel);
    logic [15:0] q;
    q = cfg.res_ohm / (16'(DT_DIV) * {8'h00, vdel});
    if (cfg.tied_ref) begin
      dt_cycles = DT_RESET;
    end else if (q > 16'(255 - DT_OFFSET_CYC)) begin
      dt_cycles = 8'hFF;
    end else begin
      dt_cycles = q[7:0] + 8'(DT_OFFSET_CYC);
    end
  endfunction

  // adaptive level at or above sense leaves the level at its floor
  always_comb begin
    vdel_diff = (cs_s > ads_s) ? cs_s - ads_s : CODE_RESET;
    vdel_prod = VDEL_GAIN_NUM * {2'b00, vdel_diff};
    vdel_next = VDEL_MIN + vdel_prod[9:VDEL_GAIN_SHIFT];
  end

  // registered level also keeps the divider off the comparator path
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      DEL_LEVEL <= VDEL_MIN;
    end else if (CLK_EN) begin
      DEL_LEVEL <= vdel_next;
    end
  end

  assign dt1 = dt_cycles(LEG1_CFG, DEL_LEVEL);
  assign dt2 = dt_cycles(LEG2_CFG, DEL_LEVEL);

  // ***************************************************
  // error amplifier limit and no-load skipping
  // ***************************************************
  logic noload_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      EA_LIMIT <= CODE_RESET;
    end else if (CLK_EN) begin
      EA_LIMIT <= (ea_s < ss_s) ? ea_s : ss_s;
    end
  end

  // hysteresis keeps light-load skipping from chattering
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      noload_reg <= 1'b1;
    end else if (CLK_EN) begin
      if (EA_LIMIT < NOLOAD_OFF) begin
        noload_reg <= 1'b1;
      end else if (EA_LIMIT > NOLOAD_ON) begin
        noload_reg <= 1'b0;
      end
    end
  end

  // ***************************************************
  // fault and soft-start sequencing
  // ***************************************************
  psb_state_t state_reg;
  psb_state_t state_next;
  logic hard_fault;
  logic kill;

  assign hard_fault = cmp_s.uvlo || cmp_s.ref_low;
  // outputs drop on the synchronised fault itself, not on the state change
  assign kill = (state_reg != ST_START) || hard_fault || cmp_s.ss_low
    || cmp_s.over_cur || noload_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (!hard_fault) state_next = ST_START;
      end
      ST_START: begin
        if (hard_fault) begin
          state_next = ST_OFF;
        end else if (cmp_s.over_cur) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (hard_fault) begin
          state_next = ST_OFF;
        end else if (cmp_s.ss_low) begin
          state_next = ST_START;
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_reg <= ST_OFF;
    end else if (CLK_EN) begin
      state_reg <= state_next;
    end
  end

  // node currents follow the next state so they line up with it
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      SS_CHARGE <= 1'b0;
      SS_SINK <= 1'b0;
      SS_DISCHARGE <= 1'b1;
      LOW_IQ <= 1'b1;
      REF_ENABLE <= 1'b0;
    end else if (CLK_EN) begin
      SS_CHARGE <= (state_next == ST_START);
      SS_SINK <= (state_next == ST_STOP);
      SS_DISCHARGE <= (state_next == ST_OFF);
      LOW_IQ <= cmp_s.uvlo;
      REF_ENABLE <= !cmp_s.uvlo;
    end
  end

  // ***************************************************
  // leg drivers
  // ***************************************************
  psb_leg u_leg1 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .phase_in(leg1_ph_reg),
    .dt_in(dt1),
    .kill(kill),
    .hi_drive(LEG1_HIGH_DRIVE),
    .lo_drive(LEG1_LOW_DRIVE)
  );

  psb_leg u_leg2 (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .phase_in(leg2_ph_reg),
    .dt_in(dt2),
    .kill(kill),
    .hi_drive(LEG2_HIGH_DRIVE),
    .lo_drive(LEG2_LOW_DRIVE)
  );

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence stop_done_s;
    CLK_EN && state_reg == ST_STOP && cmp_s.ss_low && !hard_fault;
  endsequence

  sequence all_low_s;
    !LEG1_HIGH_DRIVE && !LEG1_LOW_DRIVE && !LEG2_HIGH_DRIVE && !LEG2_LOW_DRIVE;
  endsequence

  leg1_toggle_a : assert property (
    CLK_EN && tick |=> leg1_ph_reg != $past(leg1_ph_reg))
    else $error("leg one did not flip on the oscillator tick");

  leg2_lag_a : assert property (
    CLK_EN && lag_pend_reg && !tick && lag_cnt_reg == phase_lat_reg
    |=> leg2_ph_reg == leg1_ph_reg && !lag_pend_reg)
    else $error("leg two missed its phase offset");

  noload_hold_a : assert property (
    CLK_EN && noload_reg && EA_LIMIT <= NOLOAD_ON |=> noload_reg)
    else $error("no-load released inside hysteresis band");

  ea_clamp_a : assert property (
    CLK_EN |=> EA_LIMIT <= $past(ss_s))
    else $error("error amplifier above soft-start level");

  fault_off_a : assert property (
    CLK_EN && hard_fault |=> SS_DISCHARGE && state_reg == ST_OFF && !SS_CHARGE)
    else $error("hard fault did not discharge the node");

  oc_stop_a : assert property (
    CLK_EN && state_reg == ST_START && !hard_fault && cmp_s.over_cur
    |=> SS_SINK && state_reg == ST_STOP)
    else $error("overcurrent did not start soft stop");

  kill_low_a : assert property (
    CLK_EN && kill |=> all_low_s)
    else $error("outputs not forced low on fault");

  restart_a : assert property (
    stop_done_s |=> SS_CHARGE && !SS_SINK && state_reg == ST_START)
    else $error("soft stop did not hand over to soft start");

  low_iq_a : assert property (
    CLK_EN && cmp_s.ss_low && !cmp_s.uvlo |=> !LOW_IQ && REF_ENABLE)
    else $error("low current or reference off outside lockout");

  vdel_floor_a : assert property (
    CLK_EN && cs_s <= ads_s |=> DEL_LEVEL == VDEL_MIN)
    else $error("delay level not at its floor");

endmodule
